// ---- design/ssm_pkg.sv ----
// Purpose: Shared constants, field layouts and carriers for the shared strobe memory port
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Width and size encodings are shared by both strobe control registers
package ssm_pkg;
	// Register byte offsets
	localparam logic [7:0] SSM_PRIMARY_CTRL_OFS = 8'h00;
	localparam logic [7:0] SSM_SECONDARY_CTRL_OFS = 8'h04;
	localparam logic [7:0] SSM_REQ_ADDR_OFS = 8'h08;
	localparam logic [7:0] SSM_REQ_DATA_OFS = 8'h0c;
	localparam logic [7:0] SSM_CMD_OFS = 8'h10;
	localparam logic [7:0] SSM_STATUS_OFS = 8'h14;
	localparam logic [7:0] SSM_RD_DATA_OFS = 8'h18;
	// Control register field positions
	localparam int SSM_WIDTH_LSB = 0;
	localparam int SSM_SIZE_LSB = 2;
	localparam int SSM_WAIT_LSB = 4;
	localparam int SSM_SHARE_BIT = 8;
	// Width and size encodings: 0 = 8 bits, 1 = 16 bits, 2 = 32 bits
	localparam logic [1:0] SSM_W8 = 2'h0;
	localparam logic [1:0] SSM_W16 = 2'h1;
	localparam logic [1:0] SSM_W32 = 2'h2;
	// Reset values: 32-bit width and size, no waits, sharing off
	localparam logic [31:0] SSM_CTRL_RESET = 32'h0000000a;
	localparam logic [23:0] SSM_ADDR_RESET = 24'h000000;
	localparam logic [31:0] SSM_DATA_RESET = 32'h00000000;
	localparam logic [3:0] SSM_LANES_IDLE = 4'hf;
	// Logical address bit that splits the primary and secondary strobe spaces
	localparam int SSM_SPACE_BIT = 23;
	// Strobe control carrier
	typedef struct packed {
		logic share;
		logic [2:0] waits;
		logic [1:0] size;
		logic [1:0] width;
	} ssm_ctrl_s;
	// External bus carrier
	typedef struct packed {
		logic [23:0] addr;
		logic [3:0] lanes_n;
		logic secondary_n;
		logic write_n;
	} ssm_bus_s;
endpackage : ssm_pkg

// ---- design/ssm_port.sv ----
// Purpose: External memory port with two strobe spaces sharing one bank
// Assumes: Ready input is asynchronous to i_ref_clk and synchronised here
// Notes: Logical addresses select the strobe space by their top bit
//
// Summary of operation
// - Sharing bit routes both spaces onto lanes
// - Each half uses its own control register
// - 8-bit on 32-bit memory shifts by two
// - 16-bit on 32-bit memory shifts by one
// - 32-bit on 32-bit drives all lanes except for unshared secondary
// - Unshared secondary drives only its own strobe; shared, only its selected lanes
// - Mixed size pairs cost no extra cycles
// - Settings apply per space without rewrites
// - Sharing works on 16 and 8-bit memory
// - Device translates addresses and lanes itself
// - Ready decides cycle end or extension
// - Programmed waits still need ready low
// - Ready sampled at phase one falling edge
// - Shared lanes are AND of strobes
// - 32-bit data on 32-bit memory leaves address pins unshifted
`timescale 1ns/1ns
module ssm_port (
	input wire logic i_ref_clk, // 25 MHz clock, phase one falling edge equivalent
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error for unmapped address
	input wire logic i_ready_n, // External ready pin, active low
	input wire logic [31:0] i_mem_rdata, // Memory data in
	output ssm_pkg::ssm_bus_s o_bus, // Address, lane strobes, secondary strobe, write
	output logic [31:0] o_mem_wdata, // Memory data out
	output logic o_mem_wdata_oe // Data bus drive enable
);
	import ssm_pkg::*;
	typedef enum logic [1:0] {SSM_IDLE, SSM_WAIT, SSM_ACCESS} ssm_state_e;

	ssm_state_e state_reg, state_next;
	ssm_ctrl_s pri_reg, sec_reg;
	logic [23:0] req_addr_reg;
	logic [31:0] req_data_reg, rd_data_reg;
	logic req_write_reg, done_reg;
	logic [2:0] wait_cnt_reg;
	logic [2:0] rdy_sync_reg;
	ssm_bus_s bus_reg, bus_next;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg, wdata_oe_reg;

	// Decode of APB access phase and register selection
	wire apb_setup = i_psel && !i_penable;
	// Writes land at the access edge where ready is seen high, never in setup
	wire apb_access = i_psel && i_penable && pready_reg;
	wire apb_wr = apb_access && i_pwrite;
	// Read data is prepared in setup so that it stands together with ready
	wire apb_rd = apb_setup && !i_pwrite;
	wire sel_pri = i_paddr == SSM_PRIMARY_CTRL_OFS;
	wire sel_sec = i_paddr == SSM_SECONDARY_CTRL_OFS;
	wire sel_addr = i_paddr == SSM_REQ_ADDR_OFS;
	wire sel_data = i_paddr == SSM_REQ_DATA_OFS;
	wire sel_cmd = i_paddr == SSM_CMD_OFS;
	wire sel_stat = i_paddr == SSM_STATUS_OFS;
	wire sel_rdd = i_paddr == SSM_RD_DATA_OFS;
	wire mapped = sel_pri | sel_sec | sel_addr | sel_data | sel_cmd | sel_stat | sel_rdd;
	wire busy = state_reg != SSM_IDLE;
	// Command start ignored while busy so an access in flight is never disturbed
	wire start = apb_wr && sel_cmd && !busy;

	// Space picked by address, no rewrite
	wire is_sec = req_addr_reg[SSM_SPACE_BIT];
	ssm_ctrl_s act;
	assign act = is_sec ? sec_reg : pri_reg;

	// Shift is width minus size when data is narrower
	// Data wider than memory keeps the logical address: one bus cycle only
	wire [1:0] dshift = (act.width > act.size) ? 2'(act.width - act.size) : 2'h0;
	// Device computes physical address; bit 23 only picks the space
	wire [23:0] phys_addr = {1'b0, req_addr_reg[22:0]} >> dshift;
	// Byte offset within the memory word: low logical bits scaled by data size
	wire [1:0] lane_ofs = (dshift == 2'h2) ? req_addr_reg[1:0] :
		(dshift == 2'h1 && act.size == SSM_W8) ? {1'b0, req_addr_reg[0]} :
		(dshift == 2'h1) ? {req_addr_reg[0], 1'b0} : 2'h0;
	wire [3:0] width_mask = (act.width == SSM_W32) ? 4'hf :
		(act.width == SSM_W16) ? 4'h3 : 4'h1;
	wire [3:0] size_mask = (act.size == SSM_W32) ? 4'hf :
		(act.size == SSM_W16) ? 4'h3 : 4'h1;
	// Lane selection by size and low bits
	wire [3:0] lanes_on = 4'((size_mask & width_mask) << lane_ofs);
	// Shared lanes carry AND of both active-low strobes
	wire share = pri_reg.share;
	wire [3:0] pri_lanes_n = is_sec ? SSM_LANES_IDLE : ~lanes_on;
	wire [3:0] sec_lanes_n = is_sec ? ~lanes_on : SSM_LANES_IDLE;
	wire [3:0] drive_lanes_n = share ? (pri_lanes_n & sec_lanes_n) : pri_lanes_n;
	wire sec_pin_n = share ? 1'b1 : &sec_lanes_n;

	// Ready is a pin: three stages, low counts only when last two agree
	wire rdy_low = !rdy_sync_reg[1] && !rdy_sync_reg[2];
	wire waits_done = wait_cnt_reg == 3'h0;

	// Bus cycle sequencer: programmed waits, then ready governs the end
	always_comb begin
		state_next = state_reg;
		bus_next = bus_reg;
		unique case (state_reg)
			SSM_IDLE: begin
				if (start) begin
					state_next = SSM_WAIT;
				end
			end
			SSM_WAIT: begin
				// Same single access path for every size pair
				bus_next.addr = phys_addr;
				bus_next.lanes_n = drive_lanes_n;
				bus_next.secondary_n = sec_pin_n;
				bus_next.write_n = !req_write_reg;
				state_next = SSM_ACCESS;
			end
			SSM_ACCESS: begin
				// Ready high holds the bus for another cycle
				// Programmed waits run first, ready still honoured
				if (waits_done && rdy_low) begin
					state_next = SSM_IDLE;
					bus_next.lanes_n = SSM_LANES_IDLE;
					bus_next.secondary_n = 1'b1;
					bus_next.write_n = 1'b1;
				end
			end
		endcase
	end

	// Strobe control and request registers written over APB
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pri_reg <= ssm_ctrl_s'({SSM_CTRL_RESET[SSM_SHARE_BIT], SSM_CTRL_RESET[6:0]});
			sec_reg <= ssm_ctrl_s'({SSM_CTRL_RESET[SSM_SHARE_BIT], SSM_CTRL_RESET[6:0]});
			req_addr_reg <= SSM_ADDR_RESET;
			req_data_reg <= SSM_DATA_RESET;
			req_write_reg <= 1'b0;
		end else begin
			if (apb_wr && sel_pri) begin
				pri_reg <= {i_pwdata[SSM_SHARE_BIT], i_pwdata[SSM_WAIT_LSB +: 3],
					i_pwdata[SSM_SIZE_LSB +: 2], i_pwdata[SSM_WIDTH_LSB +: 2]};
			end
			if (apb_wr && sel_sec) begin
				sec_reg <= {1'b0, i_pwdata[SSM_WAIT_LSB +: 3],
					i_pwdata[SSM_SIZE_LSB +: 2], i_pwdata[SSM_WIDTH_LSB +: 2]};
			end
			if (apb_wr && sel_addr && !busy) begin
				req_addr_reg <= i_pwdata[23:0];
			end
			if (apb_wr && sel_data && !busy) begin
				req_data_reg <= i_pwdata;
			end
			if (start) begin
				req_write_reg <= i_pwdata[0];
			end
		end
	end

	// Sequencer, wait counter, ready synchroniser and captured read data
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_reg <= SSM_IDLE;
			bus_reg <= '{addr: SSM_ADDR_RESET, lanes_n: SSM_LANES_IDLE, secondary_n: 1'b1, write_n: 1'b1};
			wait_cnt_reg <= 3'h0;
			rdy_sync_reg <= 3'h7;
			rd_data_reg <= SSM_DATA_RESET;
			done_reg <= 1'b0;
			wdata_oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bus_reg <= bus_next;
			rdy_sync_reg <= {rdy_sync_reg[1:0], i_ready_n};
			if (state_reg == SSM_WAIT) begin
				wait_cnt_reg <= act.waits;
				wdata_oe_reg <= req_write_reg;
			end else if (!waits_done) begin
				wait_cnt_reg <= wait_cnt_reg - 3'h1;
			end
			if (state_reg == SSM_ACCESS && state_next == SSM_IDLE) begin
				wdata_oe_reg <= 1'b0;
				done_reg <= 1'b1;
				if (!req_write_reg) begin
					rd_data_reg <= (i_mem_rdata >> {lane_ofs, 3'h0}) &
						{{8{size_mask[3]}}, {8{size_mask[2]}}, {8{size_mask[1]}}, 8'hff};
				end
			end else if (start) begin
				done_reg <= 1'b0;
			end
		end
	end

	// APB answer one cycle after setup; unmapped addresses report an error
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_setup;
			pslverr_reg <= apb_setup && !mapped;
			// Control words read back in register layout; spare bits read zero
			if (apb_rd) begin
				prdata_reg <= sel_pri ? {23'h000000, pri_reg.share, 1'b0, pri_reg[6:0]} :
					sel_sec ? {23'h000000, sec_reg.share, 1'b0, sec_reg[6:0]} :
					sel_addr ? {8'h00, req_addr_reg} :
					sel_data ? req_data_reg :
					sel_stat ? {30'h0, done_reg, busy} :
					sel_rdd ? rd_data_reg : 32'h00000000;
			end
		end
	end

	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_bus = bus_reg;
	assign o_mem_wdata = req_data_reg;
	assign o_mem_wdata_oe = wdata_oe_reg;

	// Assertions
	// Unshared secondary off primary lanes
	sec_lane_iso_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && is_sec && !share) |=> (o_bus.lanes_n == 4'hf))
		else $error("secondary access appeared on primary lanes");
	share_route_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && is_sec && share) |=> (o_bus.lanes_n != 4'hf && o_bus.secondary_n))
		else $error("shared secondary access missing on lanes");
	full_word_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W32 && act.width == SSM_W32 && (share || !is_sec))
		|=> (o_bus.lanes_n == 4'h0))
		else $error("32-bit access did not drive all lanes");
	byte_lane_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W8 && (share || !is_sec))
		|=> ($countones(~o_bus.lanes_n) == 1))
		else $error("byte access drove other than one lane");
	// Byte on word memory shifts by two
	byte_shift_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W8 && act.width == SSM_W32)
		|=> (o_bus.addr == {3'h0, $past(req_addr_reg[22:2])}))
		else $error("byte address not shifted by two");
	// Half on word memory shifts by one
	half_shift_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W16 && act.width == SSM_W32)
		|=> (o_bus.addr == {1'b0, $past(req_addr_reg[22:0]) >> 1}))
		else $error("halfword address not shifted by one");
	ready_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_ACCESS && !rdy_low) |=> (state_reg == SSM_ACCESS && $stable(o_bus)))
		else $error("bus changed while not ready");
	ready_end_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_ACCESS && rdy_low && waits_done) |=> (state_reg == SSM_IDLE && o_bus.lanes_n == 4'hf))
		else $error("cycle did not end on ready");
	// Byte lane follows low address bits
	byte_pos_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W8 && act.width == SSM_W32
		&& (share || !is_sec)) |=> (o_bus.lanes_n == ~(4'h1 << $past(req_addr_reg[1:0]))))
		else $error("byte access drove the wrong lane");
	// Word data on word memory keeps address
	word_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && act.size == SSM_W32 && act.width == SSM_W32)
		|=> (o_bus.addr == {1'b0, $past(req_addr_reg[22:0])}))
		else $error("word address shifted on word memory");
	// Unshared secondary uses its own strobe
	sec_pin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && is_sec && !share)
		|=> (!o_bus.secondary_n))
		else $error("unshared secondary strobe not driven");
	// Primary access leaves secondary strobe idle
	pri_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_WAIT && !is_sec)
		|=> (o_bus.secondary_n))
		else $error("primary access drove the secondary strobe");
	// Programmed waits keep the cycle open
	prog_wait_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == SSM_ACCESS && !waits_done)
		|=> (state_reg == SSM_ACCESS))
		else $error("cycle ended during programmed waits");
	// Cover the main scenarios
	shared_sec_c: cover property (@(posedge i_ref_clk) state_reg == SSM_WAIT && is_sec && share);
	wait_ext_c: cover property (@(posedge i_ref_clk) state_reg == SSM_ACCESS && !rdy_low);
	byte_word_c: cover property (@(posedge i_ref_clk)
		state_reg == SSM_WAIT && act.size == SSM_W8 && act.width == SSM_W32);
	unshared_sec_c: cover property (@(posedge i_ref_clk)
		state_reg == SSM_WAIT && is_sec && !share);
	prog_wait_c: cover property (@(posedge i_ref_clk)
		state_reg == SSM_ACCESS && !waits_done);
endmodule : ssm_port

// ---- tb/ssm_mem_model.sv ----
// Purpose: External SRAM bank with optional ready delay logic
// Assumes: Lane strobes and secondary strobe are active low
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ns
module ssm_mem_model (
	input wire logic i_clk, // Clock
	input wire logic [3:0] i_dly, // Ready delay, zero ties ready low
	input ssm_pkg::ssm_bus_s i_bus, // Bus from the port
	input wire logic [31:0] i_wdata, // Write data
	output logic o_ready_n, // Ready, active low
	output logic [31:0] o_rdata // Read data
);
	import ssm_pkg::*;
	logic [31:0] mem [256];
	logic [3:0] cnt = 4'h0;
	logic [31:0] last = 32'h0;
	wire act = (i_bus.lanes_n != 4'hf) || !i_bus.secondary_n;
	assign o_ready_n = (i_dly != 4'h0) && !(act && cnt >= i_dly);
	// Wait counter and lane writes; cycle end is unknown here, so write each cycle
	always @(posedge i_clk) begin
		cnt <= act ? cnt + 4'h1 : 4'h0;
		if (act && !i_bus.write_n)
			for (int k = 0; k < 4; k++)
				if (!i_bus.lanes_n[k]) mem[i_bus.addr[7:0]][8*k+:8] <= i_wdata[8*k+:8];
		if (act && i_bus.write_n) last <= mem[i_bus.addr[7:0]];
	end
	// Released data bus never repeats the last word
	assign o_rdata = (act && i_bus.write_n) ? mem[i_bus.addr[7:0]] : ~last;
endmodule : ssm_mem_model

// ---- tb/test_shared_strobe_memory_port.sv ----
// Purpose: Self-checking bench for the shared strobe memory port
// Assumes: One bus cycle per access, ready sampled at rising edge
// Notes: Expected lanes and addresses are rebuilt from width and size
`timescale 1ns/1ns
module test_shared_strobe_memory_port;
	import ssm_pkg::*;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, rdy_n, oe, e, oe_c;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, mrd, wd, r, wd_c;
	logic [3:0] dly = 4'h0;
	ssm_bus_s bus, cap;
	int mismatches = 0, tests_run = 0, cyc = 0, n;
	always #20 clk = ~clk;
	ssm_port i_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(perr), .i_ready_n(rdy_n), .i_mem_rdata(mrd), .o_bus(bus),
		.o_mem_wdata(wd), .o_mem_wdata_oe(oe));
	ssm_mem_model i_mem (.i_clk(clk), .i_dly(dly), .i_bus(bus), .i_wdata(wd),
		.o_ready_n(rdy_n), .o_rdata(mrd));
	task end_sim;
		if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	// Request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task cfg(input logic [1:0] w0, s0, input logic [2:0] t0, input logic sh,
		input logic [1:0] w1, s1);
		apb(1'b1, SSM_PRIMARY_CTRL_OFS, 32'({sh, 1'b0, t0, s0, w0}));
		apb(1'b1, SSM_SECONDARY_CTRL_OFS, 32'({s1, w1}));
	endtask : cfg
	// Expected {lanes_n, addr}: shift by width minus size, lanes from byte offset
	function automatic logic [27:0] xl(input logic [23:0] la, input logic [1:0] wd, sz);
		int sh, mn, off;
		sh = wd > sz ? wd - sz : 0;
		mn = wd > sz ? sz : wd;
		off = wd > sz ? (int'(la[1:0]) << sz) & ((1 << wd) - 1) : 0;
		return {~4'(((1 << (1 << mn)) - 1) << off), 24'({1'b0, la[22:0]} >> sh)};
	endfunction : xl
	task acc(input logic [23:0] la, input logic w, input logic [27:0] ex, input logic sn,
		input int len);
		apb(1'b1, SSM_REQ_ADDR_OFS, {8'h00, la});
		apb(1'b1, SSM_REQ_DATA_OFS, 32'h12345678);
		apb(1'b1, SSM_CMD_OFS, {31'h0, w});
		n = 0;
		while (bus.lanes_n == 4'hf && bus.secondary_n) @(posedge clk);
		cap = bus;
		oe_c = oe;
		wd_c = wd;
		while (bus === cap) begin
			n++;
			@(posedge clk);
		end
		chk("lanes", ex[27:24], cap.lanes_n);
		chk("addr", ex[23:0], cap.addr);
		chk("sec_n", sn, cap.secondary_n);
		chk("write_n", !w, cap.write_n);
		chk("oe", w, oe_c);
		if (w) chk("wdata", 32'h12345678, wd_c);
		chk("idle", 5'h1f, {bus.lanes_n, bus.secondary_n});
		chk("oe_end", 0, oe);
		if (len == 0) chk("ext_len", 1, n > dly);
		else chk("len", len, n);
		apb(1'b0, SSM_STATUS_OFS, 32'h0);
		chk("status", 2, r[1:0]);
		if (!w) apb(1'b0, SSM_RD_DATA_OFS, 32'h0);
	endtask : acc
	task t_regs;
		apb(1'b0, SSM_PRIMARY_CTRL_OFS, 32'h0);
		chk("ctrl0", SSM_CTRL_RESET, r);
		apb(1'b1, SSM_SECONDARY_CTRL_OFS, 32'h0000010a);
		apb(1'b0, SSM_SECONDARY_CTRL_OFS, 32'h0);
		chk("ctrl1", SSM_CTRL_RESET, r);
		apb(1'b0, 8'h1c, 32'h0);
		chk("slverr", 1, e);
		chk("unmapped", 0, r);
	endtask : t_regs
	task t_pairs;
		logic [1:0] sp [3];
		logic [1:0] ss [3];
		logic [31:0] rx [3];
		sp = '{SSM_W16, SSM_W32, SSM_W16};
		ss = '{SSM_W8, SSM_W8, SSM_W32};
		rx = '{32'h44, 32'h44, 32'h44332211};
		for (int i = 0; i < 3; i++) begin
			cfg(SSM_W32, sp[i], 3'h0, 1'b1, SSM_W32, ss[i]);
			acc(24'h007fff, 1'b1, xl(24'h007fff, SSM_W32, sp[i]), 1'b1, 1);
			i_mem.mem[8'hff] = 32'h44332211;
			acc(24'h90ffff, 1'b0, xl(24'h90ffff, SSM_W32, ss[i]), 1'b1, 1);
			chk("rdata", rx[i], r);
			acc(24'h007ffe, 1'b0, xl(24'h007ffe, SSM_W32, sp[i]), 1'b1, 1);
		end
	endtask : t_pairs
	task t_modes;
		cfg(SSM_W32, SSM_W8, 3'h0, 1'b0, SSM_W32, SSM_W8);
		acc(24'h90fffe, 1'b0, {4'hf, 24'(xl(24'h90fffe, SSM_W32, SSM_W8))}, 1'b0, 1);
		cfg(SSM_W16, SSM_W8, 3'h0, 1'b1, SSM_W16, SSM_W16);
		acc(24'h000003, 1'b1, xl(24'h000003, SSM_W16, SSM_W8), 1'b1, 1);
		acc(24'h900001, 1'b0, xl(24'h900001, SSM_W16, SSM_W16), 1'b1, 1);
		cfg(SSM_W8, SSM_W8, 3'h3, 1'b1, SSM_W8, SSM_W8);
		acc(24'h000006, 1'b0, xl(24'h000006, SSM_W8, SSM_W8), 1'b1, 4);
		acc(24'h900006, 1'b0, xl(24'h900006, SSM_W8, SSM_W8), 1'b1, 1);
		dly <= 4'h4;
		acc(24'h900005, 1'b1, xl(24'h900005, SSM_W8, SSM_W8), 1'b1, 0);
		dly <= 4'h0;
	endtask : t_modes
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_pairs();
		t_modes();
		end_sim();
	end
endmodule : test_shared_strobe_memory_port
